// [trim_defines.vh]
// Register indices, field layouts, reset values for the trim register bank
`ifndef TRIM_DEFINES_VH
`define TRIM_DEFINES_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_CORE_A_DUAL_TIMING 10'h310
`define IDX_CORE_B_DUAL_TIMING 10'h313
`define IDX_CORE_A_SINGLE_INA_TIMING 10'h314
`define IDX_CORE_B_SINGLE_INA_TIMING 10'h315
`define IDX_CORE_A_SINGLE_INB_TIMING 10'h31a
`define IDX_CORE_B_SINGLE_INB_TIMING 10'h31b
`define IDX_CORE_A_DUAL_INA_OFFSET 10'h344
`define IDX_TRIM_CTRL 10'h300
`define IDX_TRIM_STATUS 10'h301

// ==========================================================================
// Widths and fields
`define TIMING_W 8
`define OFFSET_REG_W 16
`define OFFSET_W 12
`define OFFSET_MSB 11
`define CTRL_SINGLE_BIT 0
`define CTRL_INB_BIT 1
`define CTRL_FGCAL_BIT 2
`define CTRL_RELOAD_BIT 3
`define STAT_LOADED_BIT 0
`define STAT_CORE_A_APPLY_BIT 1
`define STAT_CORE_B_APPLY_BIT 2
`define STAT_OFFSET_APPLY_BIT 3

// ==========================================================================
// Reset values
`define TIMING_RESET 8'h00
`define OFFSET_RESET 16'h0000
`define CTRL_RESET 3'h0

`endif

// [trim_select.v]
// Per-core selection of the timing trim that matches the operating mode
`timescale 1ns/1ps
module trim_select #(
  parameter WIDTH = 8,
  parameter DUAL_NEEDS_FGCAL = 0
) (
  input wire single_mode,
  input wire sample_inb,
  input wire fgcal_en,
  input wire [WIDTH-1:0] dual_trim,
  input wire [WIDTH-1:0] single_ina_trim,
  input wire [WIDTH-1:0] single_inb_trim,
  output reg [WIDTH-1:0] trim,
  output reg apply
);

  // ========================================================================
  // Selection
  // Unused modes yield zero, so a stale register never leaks to the core
  always @* begin
    trim = {WIDTH{1'b0}};
    apply = 1'b0;
    if (!single_mode) begin
      if (fgcal_en || (DUAL_NEEDS_FGCAL == 0)) begin
        trim = dual_trim;
        apply = 1'b1;
      end
    end else if (fgcal_en) begin
      if (sample_inb) begin
        trim = single_inb_trim;
      end else begin
        trim = single_ina_trim;
      end
      apply = 1'b1;
    end
  end

endmodule // trim_select

// [sample_timing_offset_trim_regs.v]
// APB register bank of sampling-instant trims for two cores and an offset trim for core A
//
// Contract
// - Each timing trim register holds eight bits shifting its core's sampling.
// - Only the trim matching core, channel mode and input is applied.
// - After initialization every trim holds its fuse-loaded factory value.
// - Software reads back and overwrites trims; reads return held value.
// - Index 0x310 trims core A sampling in dual channel mode.
// - Index 0x313 trims core B in dual mode with calibration enabled.
// - Index 0x314 trims core A, single mode, calibration, input A.
// - Index 0x315 trims core B, single mode, calibration, input A.
// - Index 0x31A trims core A, single mode, calibration, input B.
// - Index 0x31B trims core B, single mode, calibration, input B.
// - Index 0x344 twelve-bit offset for core A, dual, input A, calibration.
`timescale 1ns/1ps
`include "trim_defines.vh"

module sample_timing_offset_trim_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fuse_ready,
  input wire [7:0] fuse_core_a_dual_timing,
  input wire [7:0] fuse_core_b_dual_timing,
  input wire [7:0] fuse_core_a_single_ina_timing,
  input wire [7:0] fuse_core_b_single_ina_timing,
  input wire [7:0] fuse_core_a_single_inb_timing,
  input wire [7:0] fuse_core_b_single_inb_timing,
  input wire [15:0] fuse_core_a_dual_ina_offset,
  output reg [7:0] core_a_timing,
  output reg core_a_timing_apply,
  output reg [7:0] core_b_timing,
  output reg core_b_timing_apply,
  output reg [11:0] core_a_offset,
  output reg core_a_offset_apply,
  output reg trims_loaded
);

  // ========================================================================
  // Load sequencer states
  localparam [1:0] ST_WAIT_FUSE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;

  // ========================================================================
  // Register storage
  reg [7:0] core_a_dual_timing_trim;
  reg [7:0] core_b_dual_timing_trim;
  reg [7:0] core_a_single_ina_timing_trim;
  reg [7:0] core_b_single_ina_timing_trim;
  reg [7:0] core_a_single_inb_timing_trim;
  reg [7:0] core_b_single_inb_timing_trim;
  reg [15:0] core_a_dual_ina_offset_trim;
  reg single_mode;
  reg sample_inb;
  reg fgcal_en;

  // ========================================================================
  // Bus decode
  wire [9:0] reg_index;
  wire access_phase;
  wire wr_commit;
  wire rd_sample;
  wire load_now;
  wire reload_req;
  wire hit_a_dual;
  wire hit_b_dual;
  wire hit_a_sina;
  wire hit_b_sina;
  wire hit_a_sinb;
  wire hit_b_sinb;
  wire hit_offset;
  wire hit_ctrl;
  wire hit_status;
  wire mapped;
  wire running;

  assign reg_index = paddr[11:2];
  assign access_phase = psel && penable;
  // Writes land only at the edge where pready is seen high
  assign wr_commit = access_phase && pready && pwrite && !pslverr;
  assign rd_sample = access_phase && !pready && (state == ST_RUN);
  assign load_now = (state == ST_LOAD);
  // Leaving run for a reload drops every apply at once, so stale trims
  // never stand beside a low trims_loaded while fuses are refetched
  assign running = (state == ST_RUN) && (next_state == ST_RUN);

  assign hit_a_dual = (reg_index == `IDX_CORE_A_DUAL_TIMING);
  assign hit_b_dual = (reg_index == `IDX_CORE_B_DUAL_TIMING);
  assign hit_a_sina = (reg_index == `IDX_CORE_A_SINGLE_INA_TIMING);
  assign hit_b_sina = (reg_index == `IDX_CORE_B_SINGLE_INA_TIMING);
  assign hit_a_sinb = (reg_index == `IDX_CORE_A_SINGLE_INB_TIMING);
  assign hit_b_sinb = (reg_index == `IDX_CORE_B_SINGLE_INB_TIMING);
  assign hit_offset = (reg_index == `IDX_CORE_A_DUAL_INA_OFFSET);
  assign hit_ctrl = (reg_index == `IDX_TRIM_CTRL);
  assign hit_status = (reg_index == `IDX_TRIM_STATUS);
  assign mapped = hit_a_dual || hit_b_dual || hit_a_sina || hit_b_sina ||
                  hit_a_sinb || hit_b_sinb || hit_offset || hit_ctrl ||
                  hit_status;
  assign reload_req = wr_commit && hit_ctrl && pstrb[0] &&
                      pwdata[`CTRL_RELOAD_BIT];

  // ========================================================================
  // Load sequencer
  // Fuse values are caught in ST_LOAD, the clock after fuse_ready is seen, never by reset
  always @* begin
    next_state = state;
    case (state)
      ST_WAIT_FUSE: begin
        if (fuse_ready) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (reload_req) begin
          next_state = ST_WAIT_FUSE;
        end
      end
      default: begin
        next_state = ST_WAIT_FUSE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_WAIT_FUSE;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // APB handshake
  // One wait state; transfers stall until fuse values are in place
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (access_phase && !pready && (state == ST_RUN)) begin
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ========================================================================
  // Read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_sample && !pwrite) begin
      prdata <= 32'h00000000;
      if (hit_a_dual) begin
        prdata[7:0] <= core_a_dual_timing_trim;
      end
      if (hit_b_dual) begin
        prdata[7:0] <= core_b_dual_timing_trim;
      end
      if (hit_a_sina) begin
        prdata[7:0] <= core_a_single_ina_timing_trim;
      end
      if (hit_b_sina) begin
        prdata[7:0] <= core_b_single_ina_timing_trim;
      end
      if (hit_a_sinb) begin
        prdata[7:0] <= core_a_single_inb_timing_trim;
      end
      if (hit_b_sinb) begin
        prdata[7:0] <= core_b_single_inb_timing_trim;
      end
      if (hit_offset) begin
        prdata[15:0] <= core_a_dual_ina_offset_trim;
      end
      if (hit_ctrl) begin
        prdata[2:0] <= {fgcal_en, sample_inb, single_mode};
      end
      if (hit_status) begin
        prdata[3:0] <= {core_a_offset_apply, core_b_timing_apply,
                        core_a_timing_apply, trims_loaded};
      end
    end else if (!psel) begin
      prdata <= 32'h00000000;
    end
  end

  // ========================================================================
  // Timing trim registers
  // Fuse load overrides any bus write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_dual_timing_trim <= `TIMING_RESET;
      core_b_dual_timing_trim <= `TIMING_RESET;
      core_a_single_ina_timing_trim <= `TIMING_RESET;
      core_b_single_ina_timing_trim <= `TIMING_RESET;
      core_a_single_inb_timing_trim <= `TIMING_RESET;
      core_b_single_inb_timing_trim <= `TIMING_RESET;
    end else if (load_now) begin
      core_a_dual_timing_trim <= fuse_core_a_dual_timing;
      core_b_dual_timing_trim <= fuse_core_b_dual_timing;
      core_a_single_ina_timing_trim <= fuse_core_a_single_ina_timing;
      core_b_single_ina_timing_trim <= fuse_core_b_single_ina_timing;
      core_a_single_inb_timing_trim <= fuse_core_a_single_inb_timing;
      core_b_single_inb_timing_trim <= fuse_core_b_single_inb_timing;
    end else if (wr_commit && pstrb[0]) begin
      if (hit_a_dual) begin
        core_a_dual_timing_trim <= pwdata[7:0];
      end
      if (hit_b_dual) begin
        core_b_dual_timing_trim <= pwdata[7:0];
      end
      if (hit_a_sina) begin
        core_a_single_ina_timing_trim <= pwdata[7:0];
      end
      if (hit_b_sina) begin
        core_b_single_ina_timing_trim <= pwdata[7:0];
      end
      if (hit_a_sinb) begin
        core_a_single_inb_timing_trim <= pwdata[7:0];
      end
      if (hit_b_sinb) begin
        core_b_single_inb_timing_trim <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // Offset trim register
  // Reserved upper bits are writable storage but never reach the core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_dual_ina_offset_trim <= `OFFSET_RESET;
    end else if (load_now) begin
      core_a_dual_ina_offset_trim <= fuse_core_a_dual_ina_offset;
    end else if (wr_commit && hit_offset) begin
      if (pstrb[0]) begin
        core_a_dual_ina_offset_trim[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        core_a_dual_ina_offset_trim[15:8] <= pwdata[15:8];
      end
    end
  end

  // ========================================================================
  // Mode control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fgcal_en, sample_inb, single_mode} <= `CTRL_RESET;
    end else if (wr_commit && hit_ctrl && pstrb[0]) begin
      single_mode <= pwdata[`CTRL_SINGLE_BIT];
      sample_inb <= pwdata[`CTRL_INB_BIT];
      fgcal_en <= pwdata[`CTRL_FGCAL_BIT];
    end
  end

  // ========================================================================
  // Trim selection per core
  wire [7:0] sel_a_timing;
  wire [7:0] sel_b_timing;
  wire sel_a_apply;
  wire sel_b_apply;
  wire offset_sel;

  trim_select #(
    .WIDTH(`TIMING_W),
    .DUAL_NEEDS_FGCAL(0)
  ) u_core_a_select (
    .single_mode(single_mode),
    .sample_inb(sample_inb),
    .fgcal_en(fgcal_en),
    .dual_trim(core_a_dual_timing_trim),
    .single_ina_trim(core_a_single_ina_timing_trim),
    .single_inb_trim(core_a_single_inb_timing_trim),
    .trim(sel_a_timing),
    .apply(sel_a_apply)
  );

  trim_select #(
    .WIDTH(`TIMING_W),
    .DUAL_NEEDS_FGCAL(1)
  ) u_core_b_select (
    .single_mode(single_mode),
    .sample_inb(sample_inb),
    .fgcal_en(fgcal_en),
    .dual_trim(core_b_dual_timing_trim),
    .single_ina_trim(core_b_single_ina_timing_trim),
    .single_inb_trim(core_b_single_inb_timing_trim),
    .trim(sel_b_timing),
    .apply(sel_b_apply)
  );

  // In dual mode core A sees input B only when swapped by sample_inb
  assign offset_sel = !single_mode && !sample_inb && fgcal_en;

  // ========================================================================
  // Registered core outputs
  // Outputs follow one cycle after a write, mode change or fuse load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_timing <= `TIMING_RESET;
      core_a_timing_apply <= 1'b0;
      core_b_timing <= `TIMING_RESET;
      core_b_timing_apply <= 1'b0;
      core_a_offset <= 12'h000;
      core_a_offset_apply <= 1'b0;
      trims_loaded <= 1'b0;
    end else begin
      // Nothing is applied before the factory values are in place
      core_a_timing <= running ? sel_a_timing : 8'h00;
      core_a_timing_apply <= sel_a_apply && running;
      core_b_timing <= running ? sel_b_timing : 8'h00;
      core_b_timing_apply <= sel_b_apply && running;
      if (offset_sel && running) begin
        core_a_offset <= core_a_dual_ina_offset_trim[`OFFSET_MSB:0];
      end else begin
        core_a_offset <= 12'h000;
      end
      core_a_offset_apply <= offset_sel && running;
      trims_loaded <= (next_state == ST_RUN);
    end
  end

endmodule // sample_timing_offset_trim_regs

// [sample_timing_offset_trim_regs_monitor.sv]
// Port-level assertion checker for the trim register bank
`timescale 1ns/1ps
module sample_timing_offset_trim_regs_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] core_a_timing,
  input wire core_a_timing_apply,
  input wire [7:0] core_b_timing,
  input wire core_b_timing_apply,
  input wire [11:0] core_a_offset,
  input wire core_a_offset_apply,
  input wire trims_loaded
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus handshake
  sequence s_setup; psel && !penable && trims_loaded; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_answer_time:
    assert property (s_setup ##1 s_access |-> ##1 pready)
      else $error("pready late");
  a_ready_in_access:
    assert property (pready |-> s_access) else $error("stray pready");
  a_err_read_zero:
    assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("error read data");
  // ==========================================================
  // Load and selection
  a_stall_unloaded:
    assert property (!trims_loaded |-> !pready) else $error("early pready");
  a_apply_unloaded:
    assert property (!trims_loaded |-> !core_a_timing_apply &&
      !core_b_timing_apply && !core_a_offset_apply)
      else $error("early apply");
  a_zero_unused:
    assert property ((!core_a_timing_apply |-> core_a_timing == 8'h00) and
      (!core_b_timing_apply |-> core_b_timing == 8'h00) and
      (!core_a_offset_apply |-> core_a_offset == 12'h000))
      else $error("unused trim not zero");
  a_b_needs_a:
    assert property (core_b_timing_apply |-> core_a_timing_apply)
      else $error("core b alone");
  a_offset_mode:
    assert property (core_a_offset_apply |-> core_a_timing_apply &&
      core_b_timing_apply) else $error("offset outside dual cal");
endmodule // sample_timing_offset_trim_regs_monitor

bind sample_timing_offset_trim_regs sample_timing_offset_trim_regs_monitor
  u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .core_a_timing, .core_a_timing_apply, .core_b_timing,
  .core_b_timing_apply, .core_a_offset, .core_a_offset_apply, .trims_loaded);

// [sample_timing_offset_trim_regs_bench.sv]
// Self-checking bench for the trim register bank
`timescale 1ns/1ps
module sample_timing_offset_trim_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, fuse_ready, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] fa, fb, fai, fbi, fab, fbb, at, bt;
  logic [15:0] fo;
  logic [11:0] ao;
  logic aa, ba, oa, ld;
  logic [11:0] addr [0:6];
  logic [15:0] r [0:6];
  logic [31:0] v, rd;
  logic e, s, b, f;
  logic [3:0] pstrb, strb;
  int seed, num_errors, compares, cyc;
  sample_timing_offset_trim_regs u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_ready(fuse_ready),
    .fuse_core_a_dual_timing(fa), .fuse_core_b_dual_timing(fb),
    .fuse_core_a_single_ina_timing(fai), .fuse_core_b_single_ina_timing(fbi),
    .fuse_core_a_single_inb_timing(fab), .fuse_core_b_single_inb_timing(fbb),
    .fuse_core_a_dual_ina_offset(fo), .core_a_timing(at),
    .core_a_timing_apply(aa), .core_b_timing(bt), .core_b_timing_apply(ba),
    .core_a_offset(ao), .core_a_offset_apply(oa), .trims_loaded(ld));
  // ==========================================================
  // Clock, timeout and closing
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input [31:0] x, input [31:0] g);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Holds the request until pready is sampled high
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 86;
    {num_errors, compares, cyc} = 0;
    {presetn, psel, penable, pwrite, fuse_ready, paddr, pwdata} = 0;
    pstrb = 4'h0;
    strb = 4'hf;
    {fa, fb, fai, fbi, fab, fbb} = {$random(seed), $random(seed)};
    fo = $random(seed);
    addr = '{12'hc40, 12'hc4c, 12'hc50, 12'hc54, 12'hc68, 12'hc6c, 12'hd10};
    r = '{fa, fb, fai, fbi, fab, fbb, fo};
    fork
      begin
        repeat (30) @(posedge pclk);
        fuse_ready <= 1;
      end
    join_none
    repeat (10) @(posedge pclk);
    presetn <= 1;
    // Early request stalls until fuses land
    for (int i = 0; i < 7; i++) begin
      apb(addr[i], 0, 0);
      chk("fuse default", {16'h0, r[i]}, rd);
    end
    chk("loaded", 1, ld);
    for (int i = 0; i < 7; i++) begin
      v = $random(seed);
      r[i] = (i == 6) ? v[15:0] : {8'h0, v[7:0]};
      apb(addr[i], 1, v);
      apb(addr[i], 0, 0);
      chk("readback", {16'h0, r[i]}, rd);
    end
    // Lane strobes: offset takes its upper byte only, timing trim nothing
    v = $random(seed);
    strb = 4'h2;
    apb(addr[6], 1, v);
    apb(addr[0], 1, v);
    strb = 4'hf;
    r[6][15:8] = v[15:8];
    apb(addr[6], 0, 0);
    chk("strobe offset", {16'h0, r[6]}, rd);
    apb(addr[0], 0, 0);
    chk("strobe timing", {16'h0, r[0]}, rd);
    apb(12'hffc, 0, 0);
    chk("unmapped err", 1, e);
    for (int m = 0; m < 8; m++) begin
      v = $random(seed);
      r[0] = {8'h0, v[7:0]};
      apb(addr[0], 1, v);
      apb(12'hc00, 1, m);
      repeat (2) @(posedge pclk);
      #1;
      {f, b, s} = m[2:0];
      chk("core a", {!s | f, !s ? r[0][7:0] : f ? (b ? r[4][7:0] :
        r[2][7:0]) : 8'h0}, {aa, at});
      chk("core b", {f, !f ? 8'h0 : !s ? r[1][7:0] : b ? r[5][7:0] :
        r[3][7:0]}, {ba, bt});
      chk("offset", (!s & !b & f) ? {1'b1, r[6][11:0]} : 0,
        {oa, ao});
    end
    // Mid-run reload with fresh fuse values, dual mode with calibration
    @(posedge pclk);
    {fa, fb, fai, fbi, fab, fbb} <= {$random(seed), $random(seed)};
    fo <= $random(seed);
    apb(12'hc00, 1, 32'hc);
    r = '{fa, fb, fai, fbi, fab, fbb, fo};
    for (int i = 0; i < 7; i++) begin
      apb(addr[i], 0, 0);
      chk("reloaded", {16'h0, r[i]}, rd);
    end
    apb(12'hc04, 0, 0);
    chk("status", 32'hf, rd);
    apb(12'hc00, 0, 0);
    chk("ctrl", 32'h4, rd);
    #1;
    chk("reload core a", {1'b1, r[0][7:0]}, {aa, at});
    chk("reload core b", {1'b1, r[1][7:0]}, {ba, bt});
    chk("reload offset", {1'b1, r[6][11:0]}, {oa, ao});
    end_of_test;
  end
endmodule // sample_timing_offset_trim_regs_bench
